// ===== include/io_cmd_map.vh
// Command field positions, opcodes, status codes and register offsets
// for the host-side command builder. Definitions only.
`ifndef IO_CMD_MAP_VH
`define IO_CMD_MAP_VH
// Opcodes of the three commands built by the host
`define OPC_FLUSH 8'h00
`define OPC_READ 8'h02
`define OPC_DATASET 8'h09
// Command specific status values
`define SC_CONFLICT_ATTR 8'h80
`define SC_RO_RANGE 8'h82
// Dword 12 fields
`define D12_RETRY_BIT 31
`define D12_MEDIA_BIT 30
`define D12_PI_HI 29
`define D12_PI_LO 26
`define D12_CNT_HI 15
`define D12_CNT_LO 0
// Dword 13 fields
`define D13_INCOMP_BIT 7
`define D13_SEQ_BIT 6
`define D13_LAT_HI 5
`define D13_LAT_LO 4
`define D13_FREQ_HI 3
`define D13_FREQ_LO 0
`define FREQ_LAST_VALID 4'h8
// Own APB register offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_START_LO 12'h008
`define REG_START_HI 12'h00C
`define REG_D12 12'h010
`define REG_D13 12'h014
`define REG_META_LO 12'h018
`define REG_META_HI 12'h01C
`define REG_DEST0 12'h020
`define REG_DEST1 12'h024
`define REG_DEST2 12'h028
`define REG_DEST3 12'h02C
`define REG_NSID 12'h030
`define REG_CPL 12'h034
`define REG_BLOCKS 12'h038
// Control register bits
`define CTRL_GO_BIT 0
`define CTRL_OPC_HI 9
`define CTRL_OPC_LO 8
`define CTRL_SG_BIT 16
`endif

// ===== hdl/field_pack.v
// Packs the read command dwords 12 and 13 from loose fields.
// Assumes the caller keeps reserved inputs cleared by construction.
`timescale 1ns/10ps
`default_nettype none
`include "io_cmd_map.vh"
module field_pack (
  // Dword 12 fields
  input wire reduced_retry_flag,
  input wire media_direct_flag,
  input wire [3:0] integrity_action_select,
  input wire [15:0] block_count_zero_based,
  // Dword 13 fields
  input wire [7:0] dataset_hint_byte,
  // Packed dwords
  output wire [31:0] dword12,
  output wire [31:0] dword13,
  output wire hint_reserved
);
  // Bits 25:16 of dword 12 and 31:8 of dword 13 stay zero
  assign dword12 = {reduced_retry_flag, media_direct_flag, integrity_action_select,
                    10'h000, block_count_zero_based};
  assign dword13 = {24'h000000, dataset_hint_byte};
  // Frequency codes above one-time/prefetch/overwrite are reserved
  assign hint_reserved = (dataset_hint_byte[`D13_FREQ_HI:`D13_FREQ_LO]
                          > `FREQ_LAST_VALID);
endmodule // field_pack
`default_nettype wire

// ===== hdl/io_cmd_host.v
// Host-side command builder: software fills own APB registers, the block
// emits a 16-dword submission entry and receives completion entries.
// Assumes the device takes an entry on sq_valid & sq_ready and posts
// each completion as a one-cycle cq_valid pulse with status.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "io_cmd_map.vh"
module io_cmd_host (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Submission entry towards the device
  output wire sq_valid,
  input wire sq_ready,
  output reg [7:0] sq_opcode,
  output reg [15:0] sq_cid,
  output reg [31:0] sq_nsid,
  output reg sq_scatter_gather,
  output reg [63:0] metadata_location,
  output reg [127:0] transfer_destination,
  output reg [31:0] sq_dw10,
  output reg [31:0] sq_dw11,
  output reg [31:0] sq_dw12,
  output reg [31:0] sq_dw13,
  output reg [31:0] sq_dw14,
  output reg [31:0] sq_dw15,
  // Completion entry from the device
  input wire cq_valid,
  input wire [15:0] cq_cid,
  input wire [7:0] cq_status,
  // Status summary
  output wire busy
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] opsel_reg;
  reg scatter_gather_reg;
  reg [63:0] start_block_reg;
  reg reduced_retry_flag;
  reg media_direct_flag;
  reg [3:0] integrity_action_select;
  reg [15:0] block_count_zero_based;
  reg [7:0] dataset_hint_byte;
  reg [63:0] meta_reg;
  reg [127:0] dest_reg;
  reg [31:0] nsid_reg;
  reg [15:0] cid_reg;
  reg [7:0] cpl_status_reg;
  reg done_reg;
  reg conflict_reg;
  reg ro_range_reg;
  reg hint_err_reg;
  wire [31:0] dword12;
  wire [31:0] dword13;
  wire hint_reserved;
  wire wr_en;
  wire go;
  wire [1:0] go_op;
  wire go_sg;
  wire go_read;
  wire go_flush;
  wire cpl_hit;

  // Opcode for the 2-bit selector: 0 flush, 1 read, 2 dataset management
  function [7:0] opc_of;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: opc_of = `OPC_FLUSH;
        2'd1: opc_of = `OPC_READ;
        default: opc_of = `OPC_DATASET;
      endcase
    end
  endfunction

  field_pack pack (
    .reduced_retry_flag(reduced_retry_flag),
    .media_direct_flag(media_direct_flag),
    .integrity_action_select(integrity_action_select),
    .block_count_zero_based(block_count_zero_based),
    .dataset_hint_byte(dataset_hint_byte),
    .dword12(dword12),
    .dword13(dword13),
    .hint_reserved(hint_reserved)
  );

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign go = wr_en & (paddr == `REG_CTRL) & pwdata[`CTRL_GO_BIT] & (state_reg == ST_IDLE);
  assign sq_valid = (state_reg == ST_SEND);
  assign busy = (state_reg != ST_IDLE);
  // A go write carries its own opcode and descriptor kind, so the entry
  // takes them from the bus and not from the register it overwrites
  assign go_op = pwdata[`CTRL_OPC_HI:`CTRL_OPC_LO];
  assign go_sg = pwdata[`CTRL_SG_BIT];
  assign go_read = (go_op == 2'd1);
  assign go_flush = (go_op == 2'd0);
  // Completion belongs to the outstanding command: it echoes the tag sent
  assign cpl_hit = cq_valid & (state_reg == ST_WAIT) & (cq_cid == sq_cid);

  always @*
  begin
    case (state_reg)
      ST_IDLE: state_next = go ? ST_SEND : ST_IDLE;
      ST_SEND: state_next = sq_ready ? ST_WAIT : ST_SEND;
      ST_WAIT: state_next = cpl_hit ? ST_IDLE : ST_WAIT;
      default: state_next = ST_IDLE;
    endcase
  end

  // Register writes; command fields are frozen while busy
  always @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      opsel_reg <= 2'd0;
      scatter_gather_reg <= 1'b0;
      start_block_reg <= 64'h0000000000000000;
      reduced_retry_flag <= 1'b0;
      media_direct_flag <= 1'b0;
      integrity_action_select <= 4'h0;
      block_count_zero_based <= 16'h0000;
      dataset_hint_byte <= 8'h00;
      meta_reg <= 64'h0000000000000000;
      dest_reg <= {128{1'b0}};
      nsid_reg <= 32'h00000000;
      cid_reg <= 16'h0000;
      cpl_status_reg <= 8'h00;
      done_reg <= 1'b0;
      conflict_reg <= 1'b0;
      ro_range_reg <= 1'b0;
      hint_err_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_en && !busy)
      begin
        case (paddr)
          `REG_CTRL:
          begin
            opsel_reg <= pwdata[`CTRL_OPC_HI:`CTRL_OPC_LO];
            scatter_gather_reg <= pwdata[`CTRL_SG_BIT];
          end
          `REG_START_LO: start_block_reg[31:0] <= pwdata;
          `REG_START_HI: start_block_reg[63:32] <= pwdata;
          `REG_D12:
          begin
            reduced_retry_flag <= pwdata[`D12_RETRY_BIT];
            media_direct_flag <= pwdata[`D12_MEDIA_BIT];
            integrity_action_select <= pwdata[`D12_PI_HI:`D12_PI_LO];
            block_count_zero_based <= pwdata[`D12_CNT_HI:`D12_CNT_LO];
          end
          `REG_D13: dataset_hint_byte <= pwdata[7:0];
          `REG_META_LO: meta_reg[31:0] <= pwdata;
          `REG_META_HI: meta_reg[63:32] <= pwdata;
          `REG_DEST0: dest_reg[31:0] <= pwdata;
          `REG_DEST1: dest_reg[63:32] <= pwdata;
          `REG_DEST2: dest_reg[95:64] <= pwdata;
          `REG_DEST3: dest_reg[127:96] <= pwdata;
          `REG_NSID: nsid_reg <= pwdata;
          default: ;
        endcase
      end
      // Tag for the next command; the current one leaves with the entry
      if (go)
      begin
        cid_reg <= cid_reg + 16'h0001;
        done_reg <= 1'b0;
        hint_err_reg <= 1'b0;
      end
      // Set wins over a status-register clear in the same cycle
      if (cpl_hit)
      begin
        cpl_status_reg <= cq_status;
        done_reg <= 1'b1;
        conflict_reg <= (opsel_reg == 2'd2) && (cq_status == `SC_CONFLICT_ATTR);
        ro_range_reg <= (opsel_reg == 2'd2) && (cq_status == `SC_RO_RANGE);
      end
      else if (wr_en && paddr == `REG_STATUS)
      begin
        done_reg <= done_reg & ~pwdata[1];
        conflict_reg <= conflict_reg & ~pwdata[2];
        ro_range_reg <= ro_range_reg & ~pwdata[3];
      end
      if (state_reg == ST_SEND && opsel_reg == 2'd1 && hint_reserved)
        hint_err_reg <= 1'b1;
    end
  end

  // Entry fields; a flush leaves every command-specific dword zero
  always @(posedge clock)
  begin
    if (rst)
    begin
      sq_opcode <= 8'h00;
      sq_cid <= 16'h0000;
      sq_nsid <= 32'h00000000;
      sq_scatter_gather <= 1'b0;
      metadata_location <= 64'h0000000000000000;
      transfer_destination <= {128{1'b0}};
      sq_dw10 <= 32'h00000000;
      sq_dw11 <= 32'h00000000;
      sq_dw12 <= 32'h00000000;
      sq_dw13 <= 32'h00000000;
      sq_dw14 <= 32'h00000000;
      sq_dw15 <= 32'h00000000;
    end
    else if (go)
    begin
      sq_opcode <= opc_of(go_op);
      sq_cid <= cid_reg;
      sq_nsid <= nsid_reg;
      sq_scatter_gather <= go_sg;
      metadata_location <= go_flush ? 64'h0000000000000000 : meta_reg;
      transfer_destination <= go_flush ? {128{1'b0}} : dest_reg;
      sq_dw14 <= 32'h00000000;
      sq_dw15 <= 32'h00000000;
      // Only a read fills dwords 10 to 13; the others send them zero
      if (go_read)
      begin
        sq_dw10 <= start_block_reg[31:0];
        sq_dw11 <= start_block_reg[63:32];
        sq_dw12 <= dword12;
        sq_dw13 <= dword13;
      end
      else
      begin
        sq_dw10 <= 32'h00000000;
        sq_dw11 <= 32'h00000000;
        sq_dw12 <= 32'h00000000;
        sq_dw13 <= 32'h00000000;
      end
    end
  end

  // Register read data
  always @*
  begin
    case (paddr)
      `REG_CTRL: prdata = {15'h0000, scatter_gather_reg, 6'h00, opsel_reg, 8'h00};
      `REG_STATUS: prdata = {27'h0000000, hint_err_reg, ro_range_reg, conflict_reg,
                             done_reg, busy};
      `REG_START_LO: prdata = start_block_reg[31:0];
      `REG_START_HI: prdata = start_block_reg[63:32];
      `REG_D12: prdata = dword12;
      `REG_D13: prdata = dword13;
      `REG_META_LO: prdata = meta_reg[31:0];
      `REG_META_HI: prdata = meta_reg[63:32];
      `REG_DEST0: prdata = dest_reg[31:0];
      `REG_DEST1: prdata = dest_reg[63:32];
      `REG_DEST2: prdata = dest_reg[95:64];
      `REG_DEST3: prdata = dest_reg[127:96];
      `REG_NSID: prdata = nsid_reg;
      `REG_CPL: prdata = {8'h00, cpl_status_reg, sq_cid};
      `REG_BLOCKS: prdata = {15'h0000, {1'b0, block_count_zero_based} + 17'h00001};
      default: prdata = 32'h00000000;
    endcase
  end
endmodule // io_cmd_host
`default_nettype wire

// ===== tb/io_cmd_host_props.sv
// Checker for the host command builder, bound onto its top.
// Assumes a single clock domain and the bind in the bench top.
`timescale 1ns/10ps
`default_nettype none
module io_cmd_host_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Entry and completion
  input wire logic sq_valid,
  input wire logic sq_ready,
  input wire logic [7:0] sq_opcode,
  input wire logic [15:0] sq_cid,
  input wire logic [31:0] sq_dw10,
  input wire logic [31:0] sq_dw11,
  input wire logic [31:0] sq_dw12,
  input wire logic [31:0] sq_dw13,
  input wire logic cq_valid,
  input wire logic [15:0] cq_cid,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic go = psel && penable && pwrite && paddr == 12'h000 && pwdata[0];
  wire logic hit = busy && !sq_valid && cq_valid;
  property p_go; go && !busy |=> sq_valid && busy; endproperty
  a_go: assert property (p_go) else $error("go not launched");
  property p_hold; sq_valid && !sq_ready |=> sq_valid && $stable(sq_dw12); endproperty
  a_hold: assert property (p_hold) else $error("entry dropped");
  property p_rel; sq_valid && sq_ready |=> !sq_valid; endproperty
  a_rel: assert property (p_rel) else $error("entry not released");
  property p_fl; sq_valid && sq_opcode == 8'h00 |-> (sq_dw10 | sq_dw11 | sq_dw12 | sq_dw13) == 0; endproperty
  a_fl: assert property (p_fl) else $error("flush fields set");
  property p_d13; sq_valid && sq_opcode == 8'h02 |-> sq_dw13[31:8] == 24'h0; endproperty
  a_d13: assert property (p_d13) else $error("dword 13 reserved set");
  property p_d12; sq_valid && sq_opcode == 8'h02 |-> sq_dw12[25:16] == 10'h0; endproperty
  a_d12: assert property (p_d12) else $error("dword 12 reserved set");
  property p_bsy; sq_valid |-> busy; endproperty
  a_bsy: assert property (p_bsy) else $error("idle while sending");
  property p_done; hit && cq_cid == sq_cid |=> !busy; endproperty
  a_done: assert property (p_done) else $error("completion missed");
  property p_wrong; hit && cq_cid != sq_cid |=> busy; endproperty
  a_wrong: assert property (p_wrong) else $error("foreign completion taken");
endmodule // io_cmd_host_props
`default_nettype wire

// ===== tb/io_dev_model.sv
// Device side model: takes entries after a stall, then posts completions.
// Assumes one command in flight; bench sets stall, status and a bad tag.
`timescale 1ns/10ps
`default_nettype none
module io_dev_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench controls
  input wire logic [3:0] stall,
  input wire logic [7:0] ret_status,
  input wire logic bad_cid,
  // Entry
  input wire logic sq_valid,
  output logic sq_ready,
  input wire logic [15:0] sq_cid,
  input wire logic [31:0] sq_dw12,
  // Completion
  output logic cq_valid,
  output logic [15:0] cq_cid,
  output logic [7:0] cq_status,
  output logic [16:0] blocks
);
  logic [3:0] cnt;
  logic pend;
  logic bad_sent;
  logic [15:0] tag;
  always @(posedge clock)
  begin
    cq_valid <= 1'b0;
    cq_cid <= ~cq_cid;
    cq_status <= ~cq_status;
    if (rst)
    begin
      {sq_ready, pend, bad_sent, cnt, cq_cid, cq_status, blocks} <= '0;
    end
    else if (sq_valid && !sq_ready && !pend)
    begin
      cnt <= cnt + 4'h1;
      sq_ready <= (cnt >= stall);
    end
    else if (sq_valid && sq_ready)
    begin
      sq_ready <= 1'b0;
      pend <= 1'b1;
      cnt <= 4'h0;
      tag <= sq_cid;
      blocks <= {1'b0, sq_dw12[15:0]} + 17'h1;
    end
    else if (pend)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == stall)
      begin
        cq_valid <= 1'b1;
        cq_status <= ret_status;
        cq_cid <= (bad_cid && !bad_sent) ? tag + 16'h5 : tag;
        bad_sent <= bad_cid && !bad_sent;
        pend <= bad_cid && !bad_sent;
        cnt <= 4'h0;
      end
    end
  end
endmodule // io_dev_model
`default_nettype wire

// ===== tb/io_cmd_flush_read_decode_test.sv
// Self-checking bench for the host command builder over APB.
// Assumes the device model echoes the entry tag, after one wrong tag first when bad_cid is set.
`timescale 1ns/10ps
`default_nettype none
module io_cmd_flush_read_decode_test;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, sq_valid, sq_ready, sq_sg;
  logic cq_valid, busy, bad_cid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, sq_nsid, dw10, dw11, dw12, dw13, dw14, dw15;
  logic [7:0] sq_opcode, cq_status, ret_status;
  logic [15:0] sq_cid, cq_cid;
  logic [63:0] mloc;
  logic [127:0] tdst;
  logic [3:0] stall;
  logic [16:0] blocks;
  int err_total = 0, check_count = 0, cycles = 0;
  // Columns: dword 12 written, dword 13 written, lba low, lba high, dword 12, dword 13
  logic [31:0] rows [4][6] = '{
    '{32'hFFFFFFFF, 32'hFFFFFF38, 32'h89ABCDEF, 32'h01234567, 32'hFC00FFFF, 32'h00000038},
    '{32'h40000000, 32'h000000C0, 32'h00000000, 32'hFFFFFFFF, 32'h40000000, 32'h000000C0},
    '{32'h84000007, 32'h00000057, 32'hFFFFFFFF, 32'h00000000, 32'h84000007, 32'h00000057},
    '{32'h2800FFFE, 32'h000000A6, 32'h13572468, 32'hFEDCBA98, 32'h2800FFFE, 32'h000000A6}};
  io_cmd_host uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sq_valid(sq_valid), .sq_ready(sq_ready), .sq_opcode(sq_opcode), .sq_cid(sq_cid),
    .sq_nsid(sq_nsid), .sq_scatter_gather(sq_sg), .metadata_location(mloc),
    .transfer_destination(tdst),
    .sq_dw10(dw10), .sq_dw11(dw11), .sq_dw12(dw12), .sq_dw13(dw13), .sq_dw14(dw14),
    .sq_dw15(dw15), .cq_valid(cq_valid), .cq_cid(cq_cid), .cq_status(cq_status), .busy(busy));
  io_dev_model dev (.clock(clock), .rst(rst), .stall(stall), .ret_status(ret_status),
    .bad_cid(bad_cid), .sq_valid(sq_valid), .sq_ready(sq_ready), .sq_cid(sq_cid),
    .sq_dw12(dw12), .cq_valid(cq_valid), .cq_cid(cq_cid), .cq_status(cq_status), .blocks(blocks));
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    rdata = 32'h1;
    while (rdata[0] !== 1'b0) apb(1'b0, 12'h004, 32'h0);
  endtask
  task automatic go(input logic [1:0] op, input logic scatter_gather_descriptor);
    apb(1'b1, 12'h000, {15'h0, scatter_gather_descriptor, 6'h0, op, 8'h01});
    wait_idle();
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, stall, ret_status, bad_cid} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 12'h008, rows[i][2]);
      apb(1'b1, 12'h00C, rows[i][3]);
      apb(1'b1, 12'h010, rows[i][0]);
      apb(1'b1, 12'h014, rows[i][1]);
      apb(1'b1, 12'h018, rows[i][3]);
      apb(1'b1, 12'h01C, rows[i][2]);
      for (int k = 0; k < 4; k++) apb(1'b1, 12'h020 + 12'(4 * k), rows[i][2] + k);
      apb(1'b1, 12'h030, rows[i][3]);
      stall <= 4'(i * 3);
      go(2'h1, i[0]);
      chk({dw11, dw10}, {rows[i][3], rows[i][2]});
      chk(dw12, rows[i][4]);
      chk(dw13, rows[i][5]);
      chk(mloc, {rows[i][2], rows[i][3]});
      chk(tdst, {rows[i][2] + 3, rows[i][2] + 2, rows[i][2] + 1, rows[i][2]});
      chk({sq_opcode, sq_sg}, {8'h02, i[0]});
      chk(sq_nsid, rows[i][3]);
      apb(1'b0, 12'h038, 32'h0);
      chk(rdata, {15'h0, rows[i][4][15:0]} + 32'h1);
      chk(blocks, {1'b0, rows[i][4][15:0]} + 17'h1);
    end
    for (int f = 0; f < 9; f++)
    begin
      apb(1'b1, 12'h014, {24'hFFFFFF, 4'h0, 4'(f)});
      apb(1'b0, 12'h014, 32'h0);
      chk(rdata, {28'h0, 4'(f)});
    end
    apb(1'b1, 12'h014, 32'h0000000F);
    go(2'h1, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdata[4:0], 5'h12);
    bad_cid <= 1'b1;
    stall <= 4'h9;
    go(2'h0, 1'b0);
    chk({dw10, dw11, dw12, dw13}, 128'h0);
    chk({dw14, dw15, sq_opcode}, 128'h0);
    chk({mloc, sq_nsid}, {64'h0, rows[3][3]});
    bad_cid <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      ret_status <= 8'h80 + 8'(2 * s);
      go(2'h2, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdata[3:0], 4'(4 << s) | 4'h2);
      apb(1'b0, 12'h034, 32'h0);
      chk(rdata[23:0], {8'h80 + 8'(2 * s), sq_cid});
      apb(1'b1, 12'h004, 32'hE);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(rdata[3:0], 4'h0);
    stall <= 4'hF;
    apb(1'b1, 12'h000, 32'h00000101);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h000, 32'h00000001);
    wait_idle();
    chk(sq_opcode, 8'h02);
    apb(1'b0, 12'h010, 32'h0);
    chk(rdata, rows[3][4]);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rdata, 32'h0);
    chk(pslverr, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    chk({rdata, sq_valid, busy}, 34'h0);
    print_verdict();
  end
endmodule // io_cmd_flush_read_decode_test
bind io_cmd_host io_cmd_host_props props (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sq_valid(sq_valid),
  .sq_ready(sq_ready), .sq_opcode(sq_opcode), .sq_cid(sq_cid), .sq_dw10(sq_dw10),
  .sq_dw11(sq_dw11), .sq_dw12(sq_dw12), .sq_dw13(sq_dw13), .cq_valid(cq_valid),
  .cq_cid(cq_cid), .busy(busy));
`default_nettype wire
